// File: ccs_bus_free.sv
// Detector of bus free sequences of recessive bits
`timescale 1ns/100ps
module ccs_bus_free
    import ccs_pkg::*;
#(
    parameter int FREE_BITS = CCS_FREE_BITS
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic bit_tick_i,
    input wire logic bus_bit_i,
    output logic free_o
);
    initial if (FREE_BITS < 2 || FREE_BITS > 15) $error("FREE_BITS out of range");
    logic [3:0] run_ff;
    // Counts consecutive recessive bits, pulses on the last one
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            run_ff <= 4'h0;
            free_o <= 1'b0;
        end
        else
        begin
            free_o <= 1'b0;
            if (bit_tick_i)
            begin
                if (!bus_bit_i)
                    run_ff <= 4'h0;
                else if (run_ff == 4'(FREE_BITS - 1))
                begin
                    run_ff <= 4'h0;
                    free_o <= 1'b1;
                end
                else
                    run_ff <= run_ff + 4'h1;
            end
        end
    end
endmodule

// File: ccs_bus_model.sv
// Bit engine and bus model on the far side of the command logic
`timescale 1ns/100ps
module ccs_bus_model
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic hold_i,
    input wire logic fail_i,
    output logic tick_o,
    output logic bit_o,
    output logic start_o,
    output logic ok_o,
    output logic err_o,
    output int starts_o
);
    logic busy_ff;
    logic [3:0] cnt_ff;
    // Bit ticks, bus level and one frame of nine cycles per start
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            tick_o <= 1'b0;
            bit_o <= 1'b1;
            start_o <= 1'b0;
            ok_o <= 1'b0;
            err_o <= 1'b0;
            starts_o <= 0;
        end
        else
        begin
            tick_o <= !tick_o;
            bit_o <= !busy_ff; // Recessive while idle
            start_o <= busy_ff && cnt_ff == 4'h0;
            ok_o <= busy_ff && cnt_ff == 4'h8 && !fail_i;
            err_o <= busy_ff && cnt_ff == 4'h8 && fail_i;
            cnt_ff <= busy_ff ? cnt_ff + 4'h1 : 4'h0;
            if (busy_ff && cnt_ff == 4'h8)
                busy_ff <= 1'b0;
            else if (req_i && !hold_i && !busy_ff)
            begin
                busy_ff <= 1'b1;
                starts_o <= starts_o + 1;
            end
        end
    end
endmodule

// File: ccs_err_cnt.sv
// Saturating error counter with clear, load, step up and step down
`timescale 1ns/100ps
module ccs_err_cnt #(
    parameter int W = 9
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic inc_i,
    input wire logic [W-1:0] step_i,
    input wire logic dec_i,
    output logic [W-1:0] cnt_o
);
    initial if (W < 9) $error("W must hold the bus off limit");
    logic [W:0] sum;
    assign sum = {1'b0, cnt_o} + {1'b0, step_i};
    // Clear beats load beats step up beats step down
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_o <= '0;
        else if (clr_i)
            cnt_o <= '0;
        else if (load_i)
            cnt_o <= load_val_i;
        else if (inc_i)
            cnt_o <= sum[W] ? '1 : sum[W-1:0];
        else if (dec_i && cnt_o != '0)
            cnt_o <= cnt_o - W'(1);
    end
endmodule

// File: ccs_pkg.sv
// Package of constants and types for the CAN command and status logic
//
// What this block does
// - Abort cancels only a send not started
// - Writing send request zero never cancels it
// - Send plus abort sends once, no retry
// - Loopback plus abort sends once, no retry
// - All three together act as single shot
// - Request flag clears when transmit activity sets
// - Send plus loopback without abort ignores loopback
// - Status bit 7 shows bus off
// - Status bit 6 shows counter at warning limit
// - Bits 5 and 4 show transmit, receive activity
// - Bit 3 clears on request, sets on success
// - Bit 2 shows buffer free; locked writes dropped
// - Bit 1 sticky overrun until clear command
// - Bit 0 set while a frame is queued
// - Transmit counter overflow enters bus off, halt
// - Recovery counts 128 bus free, then clears
// - Receive counter readable during recovery
// - Errors update counters; warning change raises event
// - Bus free is eleven recessive bits
package ccs_pkg;
    // ==========================================
    // Register byte addresses
    localparam logic [7:0] CCS_IDX_MODE = 8'h00;
    localparam logic [7:0] CCS_IDX_CMD = 8'h01;
    localparam logic [7:0] CCS_IDX_STATUS = 8'h02;
    localparam logic [7:0] CCS_ADR_MODE = 8'(CCS_IDX_MODE * 4);
    localparam logic [7:0] CCS_ADR_CMD = 8'(CCS_IDX_CMD * 4);
    localparam logic [7:0] CCS_ADR_STATUS = 8'(CCS_IDX_STATUS * 4);
    localparam logic [7:0] CCS_ADR_EVT_EN = 8'h10;
    localparam logic [7:0] CCS_ADR_RX_ERR = 8'h14;
    localparam logic [7:0] CCS_ADR_TX_ERR = 8'h18;
    // ==========================================
    // Command field positions
    localparam int CCS_CMD_SEND = 0;
    localparam int CCS_CMD_CANCEL = 1;
    localparam int CCS_CMD_RELEASE = 2;
    localparam int CCS_CMD_CLR_OVR = 3;
    localparam int CCS_CMD_LOOP = 4;
    // Mode and event enable field positions
    localparam int CCS_MODE_HALT = 0;
    localparam int CCS_EN_ERR = 0;
    localparam int CCS_EN_BUS_ERR = 1;
    // ==========================================
    // Reset values and protocol counts
    localparam logic CCS_RST_HALT = 1'b1;
    localparam logic [1:0] CCS_RST_EVT_EN = 2'h0;
    localparam int CCS_FREE_BITS = 11;
    localparam int CCS_RECOVER_CNT = 128;
    localparam logic [8:0] CCS_WARN_LIMIT = 9'h060;
    localparam logic [8:0] CCS_REC_BUSOFF = 9'h07F;
    localparam logic [8:0] CCS_TX_ERR_STEP = 9'h008;
    // ==========================================
    // Status flags as seen at the status register
    typedef struct packed {
        logic bus_off_flag;
        logic error_warning_flag;
        logic tx_active_flag;
        logic rx_active_flag;
        logic tx_complete_flag;
        logic tx_buffer_free_flag;
        logic rx_overrun_flag;
        logic rx_frame_present_flag;
    } ccs_status_t;
    // Transmit request sequencer states
    typedef enum logic [1:0] {
        CCS_TX_IDLE = 2'b00,
        CCS_TX_PEND = 2'b01,
        CCS_TX_SEND = 2'b10
    } ccs_tx_state_t;
endpackage

// File: ccs_top.sv
// Command and status logic of the CAN controller with its APB slave
`timescale 1ns/100ps
module ccs_top #(
    parameter int RX_CNT_W = 6
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Bit engine, same clock
    input wire logic bit_tick_i,
    input wire logic bus_bit_i,
    input wire logic tx_start_i,
    input wire logic tx_ok_i,
    input wire logic tx_err_i,
    input wire logic tx_lost_i,
    input wire logic rx_busy_i,
    input wire logic rx_err_i,
    input wire logic rx_ok_i,
    input wire logic rx_store_i,
    input wire logic rx_lost_i,
    // Host transmit buffer write strobe
    input wire logic txb_wr_i,
    output logic txb_wr_o,
    // Requests toward the bit engine and queue
    output logic send_request_o,
    output logic single_shot_o,
    output logic loopback_o,
    output logic halt_mode_o,
    output logic bus_ready_o,
    output logic release_rx_frame_o,
    // Events toward the interrupt register
    output logic err_evt_o,
    output logic bus_err_evt_o,
    output ccs_pkg::ccs_status_t status_o
);
    import ccs_pkg::*;

    initial if (RX_CNT_W < 1 || RX_CNT_W > 16) $error("RX_CNT_W out of range");

    // ==========================================
    // APB decode
    logic setup_acc;
    logic wr_fire;
    logic cmd_wr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [1:0] evt_en_ff;
    logic [8:0] tec;
    logic [8:0] rec;
    ccs_status_t stat;

    function automatic logic addr_known(input logic [7:0] a);
        return a == CCS_ADR_MODE || a == CCS_ADR_CMD || a == CCS_ADR_STATUS ||
               a == CCS_ADR_EVT_EN || a == CCS_ADR_RX_ERR || a == CCS_ADR_TX_ERR;
    endfunction

    // One wait state: answer is prepared in the first access cycle
    assign setup_acc = psel_i && penable_i && !pready_o;
    assign wr_fire = psel_i && penable_i && pready_o && pwrite_i && addr_known(paddr_i);
    assign cmd_wr = wr_fire && paddr_i == CCS_ADR_CMD;

    // Read multiplexer; command word reads as zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err = !addr_known(paddr_i);
        unique case (paddr_i)
            CCS_ADR_MODE: rd_data = {31'h0000_0000, halt_mode_o};
            CCS_ADR_STATUS: rd_data = {24'h00_0000, stat};
            CCS_ADR_EVT_EN: rd_data = {30'h0000_0000, evt_en_ff};
            CCS_ADR_RX_ERR: rd_data = {23'h00_0000, rec};
            CCS_ADR_TX_ERR: rd_data = {23'h00_0000, tec};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Bus answer registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= setup_acc;
            prdata_o <= (setup_acc && !pwrite_i) ? rd_data : 32'h0000_0000;
            pslverr_o <= setup_acc && rd_err;
        end
    end

    // Event enable register; status writes fall through unused
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            evt_en_ff <= CCS_RST_EVT_EN;
        else if (wr_fire && paddr_i == CCS_ADR_EVT_EN)
            evt_en_ff <= pwdata_i[1:0];
    end

    // ==========================================
    // Error counters and bus off
    logic bus_free;
    logic bus_off_ff;
    logic going_off;
    logic [7:0] recov_ff;
    logic recov_done;
    logic halt_fall;
    logic halt_q_ff;
    logic wait_free_ff;
    logic count_en;

    ccs_bus_free u_free (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .bit_tick_i(bit_tick_i),
        .bus_bit_i(bus_bit_i),
        .free_o(bus_free)
    );

    assign count_en = !halt_mode_o && !bus_off_ff;
    assign going_off = count_en && tec >= (9'h100 - CCS_TX_ERR_STEP) && tx_err_i;
    assign recov_done = bus_off_ff && !halt_mode_o && bus_free &&
                        recov_ff == 8'(CCS_RECOVER_CNT - 1);

    // Transmit error counter, protocol steps
    ccs_err_cnt #(.W(9)) u_tec (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(recov_done),
        .load_i(1'b0),
        .load_val_i(9'h000),
        .inc_i(count_en && tx_err_i),
        .step_i(CCS_TX_ERR_STEP),
        .dec_i(count_en && tx_ok_i),
        .cnt_o(tec)
    );

    // Receive error counter; counts down during recovery
    ccs_err_cnt #(.W(9)) u_rec (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(recov_done),
        .load_i(going_off),
        .load_val_i(CCS_REC_BUSOFF),
        .inc_i(count_en && rx_err_i),
        .step_i(9'h001),
        .dec_i((count_en && rx_ok_i) || (bus_off_ff && !halt_mode_o && bus_free)),
        .cnt_o(rec)
    );

    // Bus off flag and recovery count of bus free sequences
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bus_off_ff <= 1'b0;
            recov_ff <= 8'h00;
        end
        else if (going_off)
        begin
            bus_off_ff <= 1'b1;
            recov_ff <= 8'h00;
        end
        else if (recov_done)
        begin
            bus_off_ff <= 1'b0;
            recov_ff <= 8'h00;
        end
        else if (bus_off_ff && !halt_mode_o && bus_free)
            recov_ff <= recov_ff + 8'h01;
    end

    // Halt mode: set at reset and at bus off, host may clear
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            halt_mode_o <= CCS_RST_HALT;
        else if (going_off)
            halt_mode_o <= 1'b1;
        else if (wr_fire && paddr_i == CCS_ADR_MODE)
            halt_mode_o <= pwdata_i[CCS_MODE_HALT];
    end

    // After a plain halt exit one bus free sequence precedes traffic
    assign halt_fall = halt_q_ff && !halt_mode_o;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            halt_q_ff <= 1'b1;
            wait_free_ff <= 1'b1;
            bus_ready_o <= 1'b0;
        end
        else
        begin
            halt_q_ff <= halt_mode_o;
            if (halt_mode_o || halt_fall)
                wait_free_ff <= 1'b1;
            else if (bus_free)
                wait_free_ff <= 1'b0;
            bus_ready_o <= !halt_mode_o && !bus_off_ff && !wait_free_ff;
        end
    end

    // ==========================================
    // Transmit request sequencer
    ccs_tx_state_t tx_st_ff;
    ccs_tx_state_t nxt_tx_st;
    logic req_send;
    logic req_loop;
    logic req_cancel;
    logic cancel_ff;
    logic tx_abandon;

    assign req_send = cmd_wr && pwdata_i[CCS_CMD_SEND];
    assign req_loop = cmd_wr && pwdata_i[CCS_CMD_LOOP];
    assign req_cancel = cmd_wr && pwdata_i[CCS_CMD_CANCEL];
    assign tx_abandon = halt_mode_o || bus_off_ff;

    // Next state of the sequencer
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        unique case (tx_st_ff)
            CCS_TX_IDLE:
                if (!tx_abandon && (req_send || req_loop))
                    nxt_tx_st = CCS_TX_PEND;
            CCS_TX_PEND:
                if (tx_abandon || (req_cancel && !tx_start_i))
                    nxt_tx_st = CCS_TX_IDLE;
                else if (tx_start_i)
                    nxt_tx_st = CCS_TX_SEND;
            CCS_TX_SEND:
                if (tx_abandon || going_off || tx_ok_i)
                    nxt_tx_st = CCS_TX_IDLE;
                else if (tx_err_i || tx_lost_i)
                    nxt_tx_st = (single_shot_o || cancel_ff) ? CCS_TX_IDLE : CCS_TX_PEND;
            default: nxt_tx_st = CCS_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tx_st_ff <= CCS_TX_IDLE;
        else
            tx_st_ff <= nxt_tx_st;
    end

    // Mode of the request, latched when it is accepted
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            single_shot_o <= 1'b0;
            loopback_o <= 1'b0;
        end
        else if (tx_st_ff == CCS_TX_IDLE && nxt_tx_st == CCS_TX_PEND)
        begin
            single_shot_o <= req_cancel;
            loopback_o <= req_loop && !req_send;
        end
    end

    // Abort during a running frame, before the cycle of its error report, stops any retry afterwards
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cancel_ff <= 1'b0;
        else if (nxt_tx_st == CCS_TX_IDLE)
            cancel_ff <= 1'b0;
        else if (tx_st_ff == CCS_TX_SEND && req_cancel)
            cancel_ff <= 1'b1;
    end

    // Request flag: a zero write never clears it, frame start does
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            send_request_o <= 1'b0;
        else
            send_request_o <= nxt_tx_st == CCS_TX_PEND && !tx_start_i;
    end

    // ==========================================
    // Status flags
    logic [RX_CNT_W-1:0] rx_frames_ff;
    logic release_cmd;
    logic warn_now;

    assign release_cmd = cmd_wr && pwdata_i[CCS_CMD_RELEASE];
    assign warn_now = tec >= CCS_WARN_LIMIT || rec >= CCS_WARN_LIMIT;

    // Frames held in the receive queue
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rx_frames_ff <= '0;
        else if (rx_store_i && !(release_cmd && rx_frames_ff != '0))
            rx_frames_ff <= (&rx_frames_ff) ? rx_frames_ff : rx_frames_ff + RX_CNT_W'(1);
        else if (!rx_store_i && release_cmd && rx_frames_ff != '0)
            rx_frames_ff <= rx_frames_ff - RX_CNT_W'(1);
    end

    // Status register flags; only hardware writes them
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            stat <= 8'h04;
        else
        begin
            stat.bus_off_flag <= going_off || (bus_off_ff && !recov_done);
            stat.error_warning_flag <= !recov_done && (warn_now || going_off);
            stat.tx_active_flag <= nxt_tx_st == CCS_TX_SEND;
            stat.rx_active_flag <= rx_busy_i;
            if (tx_st_ff == CCS_TX_IDLE && nxt_tx_st == CCS_TX_PEND)
                stat.tx_complete_flag <= 1'b0;
            else if (tx_st_ff == CCS_TX_SEND && tx_ok_i)
                stat.tx_complete_flag <= 1'b1;
            stat.tx_buffer_free_flag <= nxt_tx_st == CCS_TX_IDLE;
            if (rx_lost_i)
                stat.rx_overrun_flag <= 1'b1;
            else if (cmd_wr && pwdata_i[CCS_CMD_CLR_OVR])
                stat.rx_overrun_flag <= 1'b0;
            stat.rx_frame_present_flag <= rx_store_i || (rx_frames_ff != '0 &&
                !(release_cmd && rx_frames_ff == RX_CNT_W'(1)));
        end
    end

    // Buffer writes pass only while the buffer is free
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            txb_wr_o <= 1'b0;
        else
            txb_wr_o <= txb_wr_i && stat.tx_buffer_free_flag;
    end

    // ==========================================
    // Events, pulses, status copy
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            err_evt_o <= 1'b0;
            bus_err_evt_o <= 1'b0;
            release_rx_frame_o <= 1'b0;
            status_o <= 8'h04;
        end
        else
        begin
            err_evt_o <= evt_en_ff[CCS_EN_ERR] && (going_off || recov_done ||
                (count_en && warn_now != stat.error_warning_flag));
            bus_err_evt_o <= evt_en_ff[CCS_EN_BUS_ERR] && going_off;
            release_rx_frame_o <= release_cmd;
            status_o <= stat;
        end
    end

    // ==========================================
    // Checks
    a_off_forces_halt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        going_off |=> halt_mode_o && bus_off_ff && rec == CCS_REC_BUSOFF)
        else $error("bus off did not force halt and counter load");
    a_cancel_pending: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_PEND && req_cancel && !tx_start_i) |=> tx_st_ff == CCS_TX_IDLE)
        else $error("abort left a pending send");
    a_run_not_cut: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_SEND && req_cancel && !tx_ok_i && !tx_err_i && !tx_lost_i && !tx_abandon)
        |=> tx_st_ff == CCS_TX_SEND)
        else $error("abort stopped a running frame");
    a_zero_keeps_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_PEND && cmd_wr && !pwdata_i[CCS_CMD_CANCEL] && !tx_start_i && !tx_abandon)
        |=> send_request_o)
        else $error("request lost without abort");
    a_single_no_retry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_SEND && single_shot_o && (tx_err_i || tx_lost_i))
        |=> tx_st_ff == CCS_TX_IDLE)
        else $error("single shot frame retried");
    a_req_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stat.tx_active_flag |-> !send_request_o)
        else $error("request flag set while transmitting");
    a_loop_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_IDLE && !tx_abandon && req_send && req_loop && !req_cancel)
        |=> !loopback_o && !single_shot_o)
        else $error("loopback kept with send request");
    a_done_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tx_st_ff == CCS_TX_SEND && tx_ok_i) |=> stat.tx_complete_flag ##1 status_o.tx_complete_flag)
        else $error("completion flag not set");
    a_overrun_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (stat.rx_overrun_flag && !(cmd_wr && pwdata_i[CCS_CMD_CLR_OVR])) |=> stat.rx_overrun_flag)
        else $error("overrun flag dropped without clear");
    a_warn_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (warn_now && !recov_done) |=> stat.error_warning_flag)
        else $error("warning flag missing");
    a_locked_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (txb_wr_i && !stat.tx_buffer_free_flag) |=> !txb_wr_o)
        else $error("buffer write passed while locked");
endmodule

// File: tb_ccs_top.sv
// Testbench of the command and status logic
`timescale 1ns/100ps
module tb_ccs_top;
    import ccs_pkg::*;
    logic clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
    logic pready_o, pslverr_o, bit_tick_i, bus_bit_i, tx_start_i, tx_ok_i, tx_err_i, e;
    logic rx_busy_i = 0, rx_store_i = 0, rx_lost_i = 0, txb_wr_i = 0, hold = 0, fail = 0;
    logic rx_err_i = 0, rx_ok_i = 0, lose = 0;
    logic txb_wr_o, send_request_o, single_shot_o, loopback_o, halt_mode_o;
    logic bus_ready_o, release_rx_frame_o, err_evt_o, bus_err_evt_o;
    ccs_status_t status_o;
    logic [4:0] codes [4] = '{5'h03, 5'h12, 5'h13, 5'h03};
    int mismatches = 0, samples_checked = 0, starts, s0, nbe = 0, nev = 0, i;
    ccs_top i_dut (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .bit_tick_i, .bus_bit_i, .tx_start_i, .tx_ok_i, .tx_err_i(tx_err_i && !lose),
        .tx_lost_i(tx_err_i && lose), .rx_busy_i, .rx_err_i, .rx_ok_i, .rx_store_i, .rx_lost_i,
        .txb_wr_i, .txb_wr_o, .send_request_o, .single_shot_o, .loopback_o, .halt_mode_o,
        .bus_ready_o, .release_rx_frame_o, .err_evt_o, .bus_err_evt_o, .status_o);
    ccs_bus_model i_bus (.clk_i, .rst_b_i, .req_i(send_request_o), .hold_i(hold), .fail_i(fail),
        .tick_o(bit_tick_i), .bit_o(bus_bit_i), .start_o(tx_start_i), .ok_o(tx_ok_i),
        .err_o(tx_err_i), .starts_o(starts));
    // Clock and event counters
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (bus_err_evt_o === 1'b1) nbe <= nbe + 1;
    always @(posedge clk_i) if (err_evt_o === 1'b1) nev <= nev + 1;
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x);
    endtask
    task results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #200000;
        mismatches++;
        results();
    end
    // Test sequence
    initial
    begin
        tick(6);
        rst_b_i <= 1'b1;
        tick(1);
        chk(status_o, 8'h04);
        rdc(CCS_ADR_MODE, 8'h01);
        wr(CCS_ADR_STATUS, 32'h0000_00FF);
        rdc(CCS_ADR_STATUS, 8'h04);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(e, 1'b1);
        $display("end reset");
        wr(CCS_ADR_EVT_EN, 32'h0000_0003);
        wr(CCS_ADR_MODE, 32'h0000_0000);
        tick(60);
        chk(bus_ready_o, 1'b1);
        hold <= 1'b1;
        wr(CCS_ADR_CMD, 32'h0000_0001);
        tick(3);
        chk(status_o, 8'h00);
        txb_wr_i <= 1'b1;
        tick(1);
        txb_wr_i <= 1'b0;
        tick(1);
        chk(txb_wr_o, 1'b0);
        wr(CCS_ADR_CMD, 32'h0000_0000);
        tick(2);
        chk(send_request_o, 1'b1);
        hold <= 1'b0;
        tick(6);
        chk({send_request_o, status_o[5]}, 2'b01);
        tick(10);
        chk(status_o, 8'h0C);
        txb_wr_i <= 1'b1;
        tick(1);
        txb_wr_i <= 1'b0;
        tick(1);
        chk(txb_wr_o, 1'b1);
        $display("end send");
        hold <= 1'b1;
        wr(CCS_ADR_CMD, 32'h0000_0001);
        wr(CCS_ADR_CMD, 32'h0000_0002);
        tick(3);
        chk({send_request_o, status_o}, 9'h004);
        hold <= 1'b0;
        wr(CCS_ADR_CMD, 32'h0000_0001);
        tick(2);
        wr(CCS_ADR_CMD, 32'h0000_0002);
        tick(12);
        chk(status_o, 8'h0C);
        $display("end abort");
        fail <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            s0 = starts;
            hold <= 1'b1;
            lose <= i == 3;
            wr(CCS_ADR_CMD, {27'h000_0000, codes[i]});
            tick(2);
            chk({single_shot_o, loopback_o}, {1'b1, i == 1});
            hold <= 1'b0;
            tick(30);
            chk(starts - s0, 1'b1);
            rdc(CCS_ADR_TX_ERR, 8 * (i + 1 - i / 3));
        end
        lose <= 1'b0;
        hold <= 1'b1;
        wr(CCS_ADR_CMD, 32'h0000_0011);
        tick(2);
        chk({send_request_o, single_shot_o, loopback_o}, 3'b100);
        wr(CCS_ADR_CMD, 32'h0000_0002);
        hold <= 1'b0;
        chk(status_o[6], 1'b0);
        $display("end single shot");
        rx_busy_i <= 1'b1;
        tick(3);
        chk(status_o[4], 1'b1);
        rx_busy_i <= 1'b0;
        rx_store_i <= 1'b1;
        tick(2);
        rx_store_i <= 1'b0;
        rx_lost_i <= 1'b1;
        wr(CCS_ADR_CMD, 32'h0000_0004);
        rx_lost_i <= 1'b0;
        tick(3);
        chk(status_o[1:0], 2'b11);
        wr(CCS_ADR_CMD, 32'h0000_0004);
        tick(1);
        chk(release_rx_frame_o, 1'b1);
        tick(2);
        chk(status_o[1:0], 2'b10);
        wr(CCS_ADR_CMD, 32'h0000_0008);
        tick(3);
        chk(status_o[1], 1'b0);
        rx_err_i <= 1'b1;
        tick(3);
        rx_err_i <= 1'b0;
        rx_ok_i <= 1'b1;
        tick(1);
        rx_ok_i <= 1'b0;
        rdc(CCS_ADR_RX_ERR, 9'h002);
        $display("end receive");
        wr(CCS_ADR_CMD, 32'h0000_0001);
        for (i = 0; i < 3000 && status_o[7] !== 1'b1; i++) tick(1);
        tick(2);
        chk({status_o[7:6], halt_mode_o}, 3'b111);
        rdc(CCS_ADR_RX_ERR, 9'h07F);
        chk(nbe, 1'b1);
        chk(nev, 2);
        fail <= 1'b0;
        wr(CCS_ADR_MODE, 32'h0000_0000);
        tick(1500);
        chk(status_o[7], 1'b1);
        apb(1'b0, CCS_ADR_RX_ERR, 32'h0000_0000);
        chk(r > 0 && r < 127, 1'b1);
        for (i = 0; i < 4000 && status_o[7] !== 1'b0; i++) tick(1);
        tick(2);
        chk(status_o, 8'h04);
        chk(nev, 3);
        rdc(CCS_ADR_TX_ERR, 9'h000);
        rdc(CCS_ADR_RX_ERR, 9'h000);
        $display("end bus off");
        results();
    end
endmodule
